// ===== cdcs_params.svh
`ifndef CDCS_PARAMS_SVH
`define CDCS_PARAMS_SVH

// APB byte offsets
`define CDCS_OFF_DATA 8'h00
`define CDCS_OFF_CTRL 8'h04
`define CDCS_OFF_RESET 8'h08
`define CDCS_OFF_CONFIG 8'h0c
`define CDCS_OFF_GAIN 8'h10
`define CDCS_OFF_ZERO 8'h14
`define CDCS_OFF_FLAGCLR 8'h18
`define CDCS_OFF_STATUS 8'h1c
`define CDCS_OFF_OUTCODE 8'h20

// Serial command address bytes
`define CDCS_CMD_NOP 8'h00
`define CDCS_CMD_DATA 8'h01
`define CDCS_CMD_CTRL 8'h55
`define CDCS_CMD_RESET 8'h56
`define CDCS_CMD_CONFIG 8'h57
`define CDCS_CMD_GAIN 8'h58
`define CDCS_CMD_ZERO 8'h59
`define CDCS_CMD_FLAGCLR 8'h96

// Field positions
`define CDCS_CTRL_RANGE_LSB 0
`define CDCS_CTRL_RAMP_EN_BIT 4
`define CDCS_CTRL_STEP_LSB 5
`define CDCS_CTRL_RATE_LSB 8
`define CDCS_CTRL_OUT_EN_BIT 12
`define CDCS_CFG_CHECK_EN_BIT 0
`define CDCS_CFG_CAL_EN_BIT 5
`define CDCS_RESET_SOFT_BIT 0
`define CDCS_STAT_FAULT_BIT 0
`define CDCS_STAT_RAMP_BIT 1

// Reset values and constants
`define CDCS_RST_WORD 16'h0000
`define CDCS_RST_GAIN 16'h0000
`define CDCS_UNITY_GAIN_OFFSET 17'h08000
`define CDCS_CRC_POLY 8'h07

// Frame lengths
`define CDCS_FRAME_CHECKED 6'd32

// Clock and update rates in Hz
`define CDCS_CLK_HZ 10000000
`define CDCS_RATE_HZ_0 258065
`define CDCS_RATE_HZ_1 200000
`define CDCS_RATE_HZ_2 153845
`define CDCS_RATE_HZ_3 131145
`define CDCS_RATE_HZ_4 115940
`define CDCS_RATE_HZ_5 69565
`define CDCS_RATE_HZ_6 37560
`define CDCS_RATE_HZ_7 25805
`define CDCS_RATE_HZ_8 20150
`define CDCS_RATE_HZ_9 16030
`define CDCS_RATE_HZ_10 10295
`define CDCS_RATE_HZ_11 8280
`define CDCS_RATE_HZ_12 6900
`define CDCS_RATE_HZ_13 5530
`define CDCS_RATE_HZ_14 4240
`define CDCS_RATE_HZ_15 3300

`endif

// ===== cdcs_pkg.sv
package cdcs_pkg;

	typedef logic [15:0] cdcs_word_t;

	typedef enum logic [1:0] {
		CDCS_RAMP_HOLD,
		CDCS_RAMP_UP,
		CDCS_RAMP_DOWN
	} cdcs_ramp_t;

endpackage : cdcs_pkg

// ===== cdcs_core.sv
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "cdcs_params.svh"

// How it works
// - Checked frame: 24 bits payload, 8 check
// - Check evaluated after every 32 serial clocks
// - Nonzero remainder raises alarm and fault flag
// - Fault clears by 0x96, disable, reset only
// - Failed frame updates no register, only the fault flag
// - Latch without clocks is no-op, realigns
// - Calibration enable applies gain and zero
// - Gain resets to 0x0000, 0x8000 is unity
// - Code times (gain+2^15)/2^16 plus zero
// - Corrected code saturates to resolution range
// - New calibration used on next data write
// - Slew off jumps, slew on steps at rate
// - Step size doubles per code, 1 to 128
// - Update rate chosen from sixteen listed frequencies
// - Clear ramps to zero when slew enabled
// - Status bit 1 shows ramp in progress
// - Step rate independent of output range
// - Range field selects 4-20, 0-20, 0-24
// - Range change clears the data register
// - Check polynomial is x^8+x^2+x+1
module cdcs_core
	import cdcs_pkg::*;
#(
	parameter int RES_BITS = 16,
	parameter int CLK_HZ = `CDCS_CLK_HZ
) (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	// APB slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// Serial link, sampled on CLK_IN
	input wire logic SCLK_IN,
	input wire logic SDI_IN,
	input wire logic LATCH_IN,
	input wire logic OUTPUT_CLEAR_IN,
	// Converter side
	output logic [15:0] DAC_CODE_OUT,
	output logic [2:0] RANGE_OUT,
	output logic OUTPUT_ENABLE_OUT,
	output logic ALARM_N_OUT,
	output logic RAMP_ACTIVE_OUT
);

	localparam int SHIFT = 16 - RES_BITS;
	localparam logic [18:0] CODE_MAX = 19'((1 << RES_BITS) - 1);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [7:0] crc_rem(input logic [31:0] d);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 31; i >= 0; i--) begin
			r = {r[6:0], d[i]} ^ (r[7] ? `CDCS_CRC_POLY : 8'h00);
		end
		return r;
	endfunction : crc_rem

	function automatic int rate_hz(input logic [3:0] sel);
		int f;
		f = `CDCS_RATE_HZ_0;
		unique case (sel)
			4'h0: f = `CDCS_RATE_HZ_0;
			4'h1: f = `CDCS_RATE_HZ_1;
			4'h2: f = `CDCS_RATE_HZ_2;
			4'h3: f = `CDCS_RATE_HZ_3;
			4'h4: f = `CDCS_RATE_HZ_4;
			4'h5: f = `CDCS_RATE_HZ_5;
			4'h6: f = `CDCS_RATE_HZ_6;
			4'h7: f = `CDCS_RATE_HZ_7;
			4'h8: f = `CDCS_RATE_HZ_8;
			4'h9: f = `CDCS_RATE_HZ_9;
			4'ha: f = `CDCS_RATE_HZ_10;
			4'hb: f = `CDCS_RATE_HZ_11;
			4'hc: f = `CDCS_RATE_HZ_12;
			4'hd: f = `CDCS_RATE_HZ_13;
			4'he: f = `CDCS_RATE_HZ_14;
			4'hf: f = `CDCS_RATE_HZ_15;
		endcase
		return f;
	endfunction : rate_hz

	// ****************************************
	// State
	// ****************************************
	cdcs_word_t data_reg;
	cdcs_word_t ctrl_reg;
	cdcs_word_t config_reg;
	cdcs_word_t gain_reg;
	cdcs_word_t zero_reg;
	cdcs_word_t corrected;
	cdcs_word_t out_code;
	logic frame_check_fault_flag;
	logic cleared;
	logic sclk_q;
	logic latch_q;
	logic [31:0] shreg;
	logic [31:0] held_frame;
	logic frame_ok;
	logic [5:0] bit_cnt;
	logic sclk_seen;
	logic [15:0] rate_cnt;

	wire logic frame_check_enable = config_reg[`CDCS_CFG_CHECK_EN_BIT];
	wire logic calibration_enable = config_reg[`CDCS_CFG_CAL_EN_BIT];
	wire logic ramp_enable = ctrl_reg[`CDCS_CTRL_RAMP_EN_BIT];
	wire logic [2:0] ramp_step_size = ctrl_reg[`CDCS_CTRL_STEP_LSB +: 3];
	wire logic [3:0] ramp_update_rate = ctrl_reg[`CDCS_CTRL_RATE_LSB +: 4];

	// ****************************************
	// Serial frame capture
	// ****************************************
	logic sclk_rise;
	logic latch_rise;
	logic [31:0] shifted;
	logic last_bit;

	assign sclk_rise = SCLK_IN & ~sclk_q;
	assign latch_rise = LATCH_IN & ~latch_q;
	assign shifted = {shreg[30:0], SDI_IN};
	assign last_bit = sclk_rise & frame_check_enable
		& (bit_cnt == `CDCS_FRAME_CHECKED - 6'd1);

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			sclk_q <= 1'b0;
			latch_q <= 1'b0;
		end else begin
			sclk_q <= SCLK_IN;
			latch_q <= LATCH_IN;
		end
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			shreg <= 32'h0000_0000;
			bit_cnt <= 6'd0;
			sclk_seen <= 1'b0;
			held_frame <= 32'h0000_0000;
			frame_ok <= 1'b0;
		end else if (latch_rise) begin
			bit_cnt <= 6'd0;
			sclk_seen <= 1'b0;
			frame_ok <= 1'b0;
		end else if (sclk_rise) begin
			shreg <= shifted;
			sclk_seen <= 1'b1;
			if (last_bit) begin
				bit_cnt <= 6'd0;
				held_frame <= shifted;
				frame_ok <= (crc_rem(shifted) == 8'h00);
			end else begin
				bit_cnt <= bit_cnt + 6'd1;
			end
		end
	end

	// Frame command: checked frames commit only when their remainder was zero
	logic frame_cmd;
	logic [23:0] frame_word;

	assign frame_word = frame_check_enable ? held_frame[31:8] : shreg[23:0];
	assign frame_cmd = latch_rise & (!sclk_seen | !frame_check_enable | frame_ok);

	// ****************************************
	// APB slave
	// ****************************************
	logic apb_go;
	logic [7:0] apb_cmd_addr;
	logic apb_mapped;

	// One wait state; a serial commit in the same cycle pushes the answer back
	assign apb_go = PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~frame_cmd;

	always_comb begin
		apb_mapped = 1'b1;
		apb_cmd_addr = `CDCS_CMD_NOP;
		unique case (PADDR_IN)
			`CDCS_OFF_DATA: apb_cmd_addr = `CDCS_CMD_DATA;
			`CDCS_OFF_CTRL: apb_cmd_addr = `CDCS_CMD_CTRL;
			`CDCS_OFF_RESET: apb_cmd_addr = `CDCS_CMD_RESET;
			`CDCS_OFF_CONFIG: apb_cmd_addr = `CDCS_CMD_CONFIG;
			`CDCS_OFF_GAIN: apb_cmd_addr = `CDCS_CMD_GAIN;
			`CDCS_OFF_ZERO: apb_cmd_addr = `CDCS_CMD_ZERO;
			`CDCS_OFF_FLAGCLR: apb_cmd_addr = `CDCS_CMD_FLAGCLR;
			`CDCS_OFF_STATUS: apb_cmd_addr = `CDCS_CMD_NOP;
			`CDCS_OFF_OUTCODE: apb_cmd_addr = `CDCS_CMD_NOP;
			default: apb_mapped = 1'b0;
		endcase
	end

	// ****************************************
	// Unified command stream
	// ****************************************
	logic cmd_valid;
	logic [7:0] cmd_addr;
	cdcs_word_t cmd_data;

	always_comb begin
		cmd_valid = 1'b0;
		cmd_addr = `CDCS_CMD_NOP;
		cmd_data = `CDCS_RST_WORD;
		if (frame_cmd) begin
			cmd_valid = 1'b1;
			cmd_addr = sclk_seen ? frame_word[23:16] : `CDCS_CMD_NOP;
			cmd_data = frame_word[15:0];
		end else if (apb_go & PWRITE_IN & apb_mapped) begin
			cmd_valid = 1'b1;
			cmd_addr = apb_cmd_addr;
			cmd_data = PWDATA_IN[15:0];
		end
	end

	logic soft_rst;
	logic wr_data;
	logic wr_ctrl;
	logic wr_cfg;
	logic wr_nop;

	assign soft_rst = cmd_valid & (cmd_addr == `CDCS_CMD_RESET)
		& cmd_data[`CDCS_RESET_SOFT_BIT];
	assign wr_data = cmd_valid & (cmd_addr == `CDCS_CMD_DATA) & ~OUTPUT_CLEAR_IN;
	assign wr_ctrl = cmd_valid & (cmd_addr == `CDCS_CMD_CTRL);
	assign wr_cfg = cmd_valid & (cmd_addr == `CDCS_CMD_CONFIG);
	assign wr_nop = cmd_valid & (cmd_addr == `CDCS_CMD_NOP);

	// ****************************************
	// Calibration
	// ****************************************
	logic [15:0] raw_code;
	logic [32:0] product;
	logic signed [18:0] cal_sum;
	cdcs_word_t next_corrected;

	always_comb begin
		raw_code = cmd_data >> SHIFT;
		product = 33'(raw_code) * 33'({1'b0, gain_reg} + `CDCS_UNITY_GAIN_OFFSET);
		cal_sum = $signed({2'b00, product[32:16]}) + $signed({{3{zero_reg[15]}}, zero_reg});
		if (!calibration_enable) begin
			next_corrected = raw_code;
		end else if (cal_sum < 0) begin
			next_corrected = 16'h0000;
		end else if (cal_sum > $signed(CODE_MAX)) begin
			next_corrected = CODE_MAX[15:0];
		end else begin
			next_corrected = cal_sum[15:0];
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			ctrl_reg <= `CDCS_RST_WORD;
			config_reg <= `CDCS_RST_WORD;
			gain_reg <= `CDCS_RST_GAIN;
			zero_reg <= `CDCS_RST_WORD;
		end else if (soft_rst) begin
			ctrl_reg <= `CDCS_RST_WORD;
			config_reg <= `CDCS_RST_WORD;
			gain_reg <= `CDCS_RST_GAIN;
			zero_reg <= `CDCS_RST_WORD;
		end else if (cmd_valid) begin
			if (wr_ctrl) begin
				ctrl_reg <= cmd_data;
			end
			if (wr_cfg) begin
				config_reg <= cmd_data;
			end
			if (cmd_addr == `CDCS_CMD_GAIN) begin
				gain_reg <= cmd_data;
			end
			if (cmd_addr == `CDCS_CMD_ZERO) begin
				zero_reg <= cmd_data;
			end
		end
	end

	// Calibration is sampled only here, so later gain or zero writes leave the output alone
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			data_reg <= `CDCS_RST_WORD;
			corrected <= `CDCS_RST_WORD;
		end else if (soft_rst) begin
			data_reg <= `CDCS_RST_WORD;
			corrected <= `CDCS_RST_WORD;
		end else if (wr_ctrl && cmd_data[`CDCS_CTRL_RANGE_LSB +: 3] != RANGE_OUT) begin
			data_reg <= `CDCS_RST_WORD;
			corrected <= `CDCS_RST_WORD;
		end else if (wr_data) begin
			data_reg <= cmd_data;
			corrected <= next_corrected;
		end
	end

	// Set wins over every synchronous clear source
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			frame_check_fault_flag <= 1'b0;
		end else if (last_bit && crc_rem(shifted) != 8'h00) begin
			frame_check_fault_flag <= 1'b1;
		end else if ((cmd_valid && cmd_addr == `CDCS_CMD_FLAGCLR) || soft_rst
			|| (wr_cfg && !cmd_data[`CDCS_CFG_CHECK_EN_BIT])) begin
			frame_check_fault_flag <= 1'b0;
		end
	end

	// Output holds zero after clear until new data or a no-op command (latch, or APB write to status or outcode) restores it
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			cleared <= 1'b0;
		end else if (OUTPUT_CLEAR_IN) begin
			cleared <= 1'b1;
		end else if (wr_nop || wr_data || soft_rst) begin
			cleared <= 1'b0;
		end
	end

	// ****************************************
	// Slew engine
	// ****************************************
	cdcs_word_t target;
	cdcs_word_t step;
	cdcs_word_t next_out;
	logic [16:0] gap;
	logic tick;
	cdcs_ramp_t ramp_dir;

	assign target = (cleared | OUTPUT_CLEAR_IN) ? 16'h0000 : (corrected << SHIFT);
	assign step = 16'h0001 << ramp_step_size;
	assign tick = (rate_cnt == 16'h0000);

	// Divider depends on the clock and the rate field only, never on the range
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			rate_cnt <= 16'h0000;
		end else if (tick) begin
			rate_cnt <= 16'(CLK_HZ / rate_hz(ramp_update_rate) - 1);
		end else begin
			rate_cnt <= rate_cnt - 16'h0001;
		end
	end

	always_comb begin
		if (out_code < target) begin
			ramp_dir = CDCS_RAMP_UP;
		end else if (out_code > target) begin
			ramp_dir = CDCS_RAMP_DOWN;
		end else begin
			ramp_dir = CDCS_RAMP_HOLD;
		end
		gap = 17'h00000;
		next_out = out_code;
		unique case (ramp_dir)
			CDCS_RAMP_UP: begin
				gap = {1'b0, target} - {1'b0, out_code};
				next_out = (gap > {1'b0, step}) ? out_code + step : target;
			end
			CDCS_RAMP_DOWN: begin
				gap = {1'b0, out_code} - {1'b0, target};
				next_out = (gap > {1'b0, step}) ? out_code - step : target;
			end
			CDCS_RAMP_HOLD: next_out = out_code;
		endcase
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			out_code <= 16'h0000;
		end else if (!ramp_enable) begin
			out_code <= target;
		end else if (tick) begin
			out_code <= next_out;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			DAC_CODE_OUT <= 16'h0000;
			RANGE_OUT <= 3'h0;
			OUTPUT_ENABLE_OUT <= 1'b0;
			ALARM_N_OUT <= 1'b1;
			RAMP_ACTIVE_OUT <= 1'b0;
		end else begin
			// Mirrors the next out_code, so with slew on the pin moves only on update ticks
			DAC_CODE_OUT <= (!ramp_enable ? target : (tick ? next_out : out_code)) >> SHIFT;
			RANGE_OUT <= ctrl_reg[`CDCS_CTRL_RANGE_LSB +: 3];
			OUTPUT_ENABLE_OUT <= ctrl_reg[`CDCS_CTRL_OUT_EN_BIT];
			ALARM_N_OUT <= ~frame_check_fault_flag;
			RAMP_ACTIVE_OUT <= ramp_enable & (out_code != target);
		end
	end

	logic [31:0] read_value;

	always_comb begin
		read_value = 32'h0000_0000;
		unique case (PADDR_IN)
			`CDCS_OFF_DATA: read_value = {16'h0000, data_reg};
			`CDCS_OFF_CTRL: read_value = {16'h0000, ctrl_reg};
			`CDCS_OFF_CONFIG: read_value = {16'h0000, config_reg};
			`CDCS_OFF_GAIN: read_value = {16'h0000, gain_reg};
			`CDCS_OFF_ZERO: read_value = {16'h0000, zero_reg};
			`CDCS_OFF_STATUS: begin
				read_value[`CDCS_STAT_FAULT_BIT] = frame_check_fault_flag;
				read_value[`CDCS_STAT_RAMP_BIT] = RAMP_ACTIVE_OUT;
			end
			`CDCS_OFF_OUTCODE: read_value = {16'h0000, DAC_CODE_OUT};
			default: read_value = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			PREADY_OUT <= 1'b0;
			PRDATA_OUT <= 32'h0000_0000;
			PSLVERR_OUT <= 1'b0;
		end else if (apb_go) begin
			PREADY_OUT <= 1'b1;
			PRDATA_OUT <= PWRITE_IN ? 32'h0000_0000 : read_value;
			PSLVERR_OUT <= ~apb_mapped;
		end else begin
			PREADY_OUT <= 1'b0;
			PSLVERR_OUT <= 1'b0;
		end
	end

endmodule : cdcs_core

`default_nettype wire

// ===== cdcs_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cdcs_core_assertions #(
	parameter int RES_BITS = 16
) (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	// Register bus
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	// Serial and converter
	input wire logic LATCH_IN,
	input wire logic OUTPUT_CLEAR_IN,
	input wire logic [15:0] DAC_CODE_OUT,
	input wire logic [2:0] RANGE_OUT,
	input wire logic ALARM_N_OUT,
	input wire logic RAMP_ACTIVE_OUT
);
	logic [3:0] since_cmd;
	logic [3:0] since_clr;
	logic rd_stat;
	logic cause;
	assign rd_stat = PREADY_OUT && !PWRITE_IN && PADDR_IN == 8'h1c;
	assign cause = since_cmd < 4'h6 || since_clr < 4'h6;
	// Ages saturate so a quiet bus never wraps back into a fresh cause
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN)
			since_cmd <= 4'hf;
		else if (LATCH_IN || (PSEL_IN && PWRITE_IN))
			since_cmd <= 4'h0;
		else if (since_cmd != 4'hf)
			since_cmd <= since_cmd + 4'h1;
	end
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN)
			since_clr <= 4'hf;
		else if (OUTPUT_CLEAR_IN)
			since_clr <= 4'h0;
		else if (since_clr != 4'hf)
			since_clr <= since_clr + 4'h1;
	end
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RESETN_IN);
	pready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("ready held too long");
	apb_answer_a: assert property ($rose(PENABLE_IN) && PSEL_IN |-> ##[1:3] PREADY_OUT)
		else $error("access not answered");
	slverr_map_a: assert property (PREADY_OUT && PADDR_IN > 8'h20 |-> PSLVERR_OUT)
		else $error("unmapped access accepted");
	fault_clear_a: assert property ($rose(ALARM_N_OUT) |-> since_cmd < 4'h6)
		else $error("alarm released without command");
	alarm_status_a: assert property (rd_stat |-> PRDATA_OUT[0] == !ALARM_N_OUT)
		else $error("fault bit and alarm disagree");
	ramp_status_a: assert property (rd_stat |-> PRDATA_OUT[1] == $past(RAMP_ACTIVE_OUT))
		else $error("ramp bit and ramp output disagree");
	ramp_cause_a: assert property ($rose(RAMP_ACTIVE_OUT) |-> cause)
		else $error("ramp started without cause");
	jump_cause_a: assert property ($changed(DAC_CODE_OUT) && !RAMP_ACTIVE_OUT
		&& !$past(RAMP_ACTIVE_OUT) |-> cause)
		else $error("code moved without cause");
	range_cause_a: assert property ($changed(RANGE_OUT) |-> since_cmd < 4'h6)
		else $error("range moved without write");
	range_clear_a: assert property ($changed(RANGE_OUT)
		|-> ##[0:2] (DAC_CODE_OUT == 16'h0 || RAMP_ACTIVE_OUT))
		else $error("range change kept data");
	code_sat_a: assert property ((DAC_CODE_OUT >> RES_BITS) == 16'h0)
		else $error("code beyond resolution");
endmodule : cdcs_core_assertions
`default_nettype wire

// ===== cdcs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cdcs_host_model (
	// Clock
	input wire logic clk_in,
	// Serial link
	output logic sclk_out,
	output logic sdi_out,
	output logic latch_out
);
	initial begin
		sclk_out = 1'h0;
		sdi_out = 1'h0;
		latch_out = 1'h0;
	end
	// Zero start, MSB first, so the appended byte leaves no remainder
	function automatic logic [7:0] crc8(input logic [23:0] m);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--)
			c = {c[6:0], 1'h0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction : crc8
	task automatic pulse_latch();
		@(posedge clk_in);
		latch_out <= 1'h1;
		@(posedge clk_in);
		latch_out <= 1'h0;
		repeat (2) @(posedge clk_in);
	endtask : pulse_latch
	// Bad flips the check byte's last bit to corrupt a checked frame
	task automatic frame(input logic [23:0] m, input logic chk, input logic bad);
		logic [31:0] f;
		int n;
		f = chk ? {m, crc8(m) ^ {7'h00, bad}} : {m, 8'h00};
		n = chk ? 32 : 24;
		for (int i = 31; i > 31 - n; i--) begin
			@(posedge clk_in);
			sdi_out <= f[i];
			@(posedge clk_in);
			sclk_out <= 1'h1;
			@(posedge clk_in);
			sclk_out <= 1'h0;
		end
		sdi_out <= ~f[32 - n];
		pulse_latch();
	endtask : frame
endmodule : cdcs_host_model
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdcs_params.svh"
module tb_top;
	logic clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic sclk, sdi, latch, clr, oen, alarm_n, ramp_on, err, chk;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] dac;
	logic [2:0] rng, rng_now;
	int tgt, n_mismatch, n_compared, cycles;
	int freq[16] = '{258065, 200000, 153845, 131145, 115940, 69565, 37560, 25805,
		20150, 16030, 10295, 8280, 6900, 5530, 4240, 3300};
	cdcs_core #(.RES_BITS(16), .CLK_HZ(10000000)) dut (
		.CLK_IN(clk), .RESETN_IN(resetn), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SCLK_IN(sclk), .SDI_IN(sdi),
		.LATCH_IN(latch), .OUTPUT_CLEAR_IN(clr), .DAC_CODE_OUT(dac), .RANGE_OUT(rng),
		.OUTPUT_ENABLE_OUT(oen), .ALARM_N_OUT(alarm_n), .RAMP_ACTIVE_OUT(ramp_on));
	cdcs_host_model host (.clk_in(clk), .sclk_out(sclk), .sdi_out(sdi), .latch_out(latch));
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 100000) begin
			n_mismatch++;
			finish_test();
		end
	end
	// ********
	// Tasks
	// ********
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Waits for the answer however long it takes; only the cycle ceiling ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic wr(input logic [23:0] m, input logic bad);
		host.frame(m, chk, bad);
		repeat (4) @(posedge clk);
	endtask : wr
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (4) @(posedge clk);
		while (ramp_on !== 1'h0 && n < 9000) begin
			@(posedge clk);
			n++;
		end
		repeat (2) @(posedge clk);
	endtask : wait_idle
	task automatic ramp(input int step, input int rate, input logic [2:0] r);
		int n;
		int s;
		s = 1 << step;
		apb(1'h1, `CDCS_OFF_CTRL, 32'h10 | 32'(step << 5) | 32'(rate << 8) | 32'(r));
		if (r != rng_now)
			tgt = 0;
		rng_now = r;
		wait_idle();
		check("start code", 32'(dac), 32'(tgt));
		apb(1'h1, `CDCS_OFF_DATA, 32'(tgt + 2 * s));
		for (int k = 1; k < 3; k++) begin
			n = 0;
			while (dac === 16'(tgt + (k - 1) * s) && n < 4000) begin
				@(posedge clk);
				n++;
			end
			check("step code", 32'(dac), 32'(tgt + k * s));
			if (k == 2)
				check("step period", 32'(n), 32'(10000000 / freq[rate]));
			else
				check("ramp busy", 32'(ramp_on), 32'h1);
		end
		tgt = tgt + 2 * s;
		wait_idle();
		check("ramp done", 32'(ramp_on), 32'h0);
		check("ramp end", 32'(dac), 32'(tgt));
	endtask : ramp
	// ********
	// Tests
	// ********
	initial begin
		clk = 1'h0;
		resetn = 1'h0;
		{psel, penable, pwrite, clr, chk} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		{n_mismatch, n_compared, cycles} = {32'h0, 32'h0, 32'h0};
		repeat (16) @(posedge clk);
		resetn <= 1'h1;
		apb(1'h0, `CDCS_OFF_GAIN, 32'h0);
		check("gain reset", rd, 32'h0);
		apb(1'h0, 8'h40, 32'h0);
		check("unmapped", 32'(err), 32'h1);
		$display("reset test done");
		wr(24'h011234, 1'h0);
		check("direct", 32'(dac), 32'h1234);
		wr(24'h590010, 1'h0);
		apb(1'h1, `CDCS_OFF_CONFIG, 32'h20);
		wr(24'h012000, 1'h0);
		check("half gain", 32'(dac), 32'h1010);
		wr(24'h588000, 1'h0);
		check("cal held", 32'(dac), 32'h1010);
		wr(24'h012000, 1'h0);
		check("unity gain", 32'(dac), 32'h2010);
		apb(1'h1, `CDCS_OFF_ZERO, 32'hfff0);
		wr(24'h010008, 1'h0);
		check("floor", 32'(dac), 32'h0);
		apb(1'h1, `CDCS_OFF_GAIN, 32'hffff);
		apb(1'h1, `CDCS_OFF_ZERO, 32'h0100);
		wr(24'h01ffff, 1'h0);
		check("ceiling", 32'(dac), 32'hffff);
		$display("calibration test done");
		wr(24'h570001, 1'h0);
		chk = 1'h1;
		host.pulse_latch();
		wr(24'h010abc, 1'h0);
		check("good frame", 32'(dac), 32'h0abc);
		wr(24'h010555, 1'h1);
		check("alarm", 32'(alarm_n), 32'h0);
		check("blocked", 32'(dac), 32'h0abc);
		apb(1'h0, `CDCS_OFF_STATUS, 32'h0);
		check("fault bit", 32'(rd[0]), 32'h1);
		wr(24'h010123, 1'h0);
		check("sticky", 32'(alarm_n), 32'h0);
		check("after fault", 32'(dac), 32'h0123);
		wr(24'h960000, 1'h0);
		check("fault cmd", 32'(alarm_n), 32'h1);
		wr(24'h590000, 1'h1);
		check("alarm again", 32'(alarm_n), 32'h0);
		apb(1'h1, `CDCS_OFF_CONFIG, 32'h0);
		repeat (4) @(posedge clk);
		check("fault off", 32'(alarm_n), 32'h1);
		chk = 1'h0;
		$display("frame check test done");
		for (int r = 5; r < 8; r++) begin
			apb(1'h1, `CDCS_OFF_DATA, 32'h4000);
			apb(1'h1, `CDCS_OFF_CTRL, 32'h1000 | 32'(r));
			repeat (4) @(posedge clk);
			check("range", 32'(rng), 32'(r));
			check("range clear", 32'(dac), 32'h0);
			check("out enable", 32'(oen), 32'h1);
		end
		rng_now = 3'h7;
		tgt = 0;
		for (int s = 0; s < 8; s++)
			ramp(s, 0, 3'h7);
		clr <= 1'h1;
		repeat (4) @(posedge clk);
		check("clear ramp", 32'(ramp_on), 32'h1);
		apb(1'h0, `CDCS_OFF_STATUS, 32'h0);
		check("ramp bit", 32'(rd[1]), 32'h1);
		wait_idle();
		check("cleared", 32'(dac), 32'h0);
		clr <= 1'h0;
		host.pulse_latch();
		wait_idle();
		check("restored", 32'(dac), 32'(tgt));
		for (int f = 0; f < 16; f++)
			ramp(7, f, 3'h5);
		$display("ramp test done");
		wr(24'h560001, 1'h0);
		apb(1'h0, `CDCS_OFF_GAIN, 32'h0);
		check("soft reset gain", rd, 32'h0);
		resetn <= 1'h0;
		repeat (3) @(posedge clk);
		check("reset alarm", 32'(alarm_n), 32'h1);
		resetn <= 1'h1;
		apb(1'h0, `CDCS_OFF_STATUS, 32'h0);
		check("reset status", rd, 32'h0);
		$display("reset again test done");
		finish_test();
	end
endmodule : tb_top
bind cdcs_core cdcs_core_assertions #(.RES_BITS(RES_BITS)) chk_i (
	.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
	.PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT),
	.PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .LATCH_IN(LATCH_IN),
	.OUTPUT_CLEAR_IN(OUTPUT_CLEAR_IN), .DAC_CODE_OUT(DAC_CODE_OUT), .RANGE_OUT(RANGE_OUT),
	.ALARM_N_OUT(ALARM_N_OUT), .RAMP_ACTIVE_OUT(RAMP_ACTIVE_OUT));
`default_nettype wire
